// ### core/timer8_pkg.sv
// Constants and types shared by the 8-bit one-shot/PWM timer
package timer8_pkg;
   localparam int          CNT_W          = 8;
   localparam logic [7:0]  CNT_RESET_VAL  = 8'hfc;
   localparam logic [7:0]  CNT_RELOAD_VAL = 8'hfc;
   localparam logic [7:0]  CAPTURE_TRIG_VAL = 8'hfd;
   localparam logic [7:0]  CMP_RESET_VAL  = 8'h00;
   localparam logic [1:0]  DIV_SEL_4      = 2'h0;
   localparam logic [1:0]  DIV_SEL_2      = 2'h1;
   localparam logic [1:0]  DIV_SEL_8      = 2'h2;
   localparam logic [1:0]  DIV_SEL_8000   = 2'h3;
   localparam int          PRESC_2        = 2;
   localparam int          PRESC_4        = 4;
   localparam int          PRESC_8        = 8;
   localparam int          PRESC_8000     = 8000;
   localparam int          PRESC_W        = 13;
   typedef enum logic [1:0] {MODE_PLAIN, MODE_ONE_SHOT, MODE_PWM} timer_mode_t;
endpackage

// ### core/timer8_prescaler.sv
// Tick generator: divides the CPU clock by the selected prescaler factor
`timescale 1ns/1ns
module timer8_prescaler #(
   parameter int SLOW_DIV = timer8_pkg::PRESC_8000
) (
   input  wire logic       clk_sys_in,
   input  wire logic       reset_in,
   input  wire logic       run_in,
   input  wire logic [1:0] div_sel_in,
   output logic            tick_out
);
   import timer8_pkg::*;

   logic [PRESC_W-1:0] cnt_q;
   logic [PRESC_W-1:0] limit;

   always_comb begin
      unique case (div_sel_in)
         DIV_SEL_4: limit = PRESC_W'(PRESC_4 - 1);
         DIV_SEL_2: limit = PRESC_W'(PRESC_2 - 1);
         DIV_SEL_8: limit = PRESC_W'(PRESC_8 - 1);
         DIV_SEL_8000: limit = PRESC_W'(SLOW_DIV - 1);
      endcase
   end

   // Frozen while halted, so the count resumes where it stopped
   always_ff @(posedge clk_sys_in) begin
      if (reset_in) begin
         // Starting at one makes the first tick after a restart land a whole period later
         cnt_q    <= PRESC_W'(1);
         tick_out <= 1'b0;
      end else if (!run_in) begin
         tick_out <= 1'b0;
      end else if (cnt_q >= limit) begin
         cnt_q    <= '0;
         tick_out <= 1'b1;
      end else begin
         cnt_q    <= cnt_q + PRESC_W'(1);
         tick_out <= 1'b0;
      end
   end
endmodule

// ### core/timer8_pulse_core.sv
// 8-bit free-running timer with one-shot and PWM modes, capture, compare and flags
`timescale 1ns/1ns
// What this block does
// - One-shot trigger edge loads counter FCh, drives during-pulse level, sets flag, captures.
// - One-shot trigger polarity follows the trigger edge select bit.
// - One-shot compare-1 match drives the after-pulse level.
// - One-shot trigger sets capture flag one, interrupting if capture enable set.
// - Capture flag clears after status read seeing it, then capture register access.
// - One-shot pulse lasts compare-1 value plus five prescaled ticks.
// - One-shot never sets compare flag one; compare two still flags.
// - PWM and one-shot both selected means PWM only.
// - Equal output levels hold the pin constant in one-shot or PWM.
// - One-shot: trigger pin stores fixed FDh, not the count; second capture pin works normally.
// - PWM compare values update only at the compare-2 match.
// - PWM compare-1 match drives after-pulse level, compare-2 drives during-pulse.
// - PWM compare-2 match reloads the counter with FCh.
// - PWM period and pulse equal compare value plus five ticks.
// - After-level 1, during-level 0 gives high time compare2 minus compare1.
// - PWM mode never sets either compare flag.
// - PWM compare-2 match sets capture flag one, interrupting if enabled.
// - PWM: trigger pin disconnected; second capture pin still captures.
// - Wait mode does not change timing; enabled interrupts wake from wait.
// - Halt stops the counter; interrupt wake resumes, reset restarts.
// - Capture edge during halt arms; on wake flag sets and exit count stored.
// - Five event flags; each can exit wait, none can exit halt.
// - One interrupt line: flag, its enable, and global mask clear.
// - Division field 00 /4, 01 /2, 10 /8, 11 /8000.
// - Edge select 1 chooses rising, 0 chooses falling.
module timer8_pulse_core #(
   parameter int SLOW_DIV = timer8_pkg::PRESC_8000
) (
   input  wire logic                    clk_sys_in,
   input  wire logic                    reset_in,
   input  wire logic                    halt_in,
   input  wire logic                    global_mask_in,
   input  wire logic                    one_shot_select_in,
   input  wire logic                    pwm_select_in,
   input  wire logic                    pulse_pin_enable_in,
   input  wire logic [1:0]              clock_division_field_in,
   input  wire logic                    after_pulse_level_in,
   input  wire logic                    during_pulse_level_in,
   input  wire logic                    trigger_edge_select_in,
   input  wire logic                    second_edge_select_in,
   input  wire logic                    capture_irq_enable_in,
   input  wire logic                    compare_irq_enable_in,
   input  wire logic                    overflow_irq_enable_in,
   input  wire logic [7:0]              compare_value_first_in,
   input  wire logic [7:0]              compare_value_second_in,
   input  wire logic                    status_read_in,
   input  wire logic                    capture_first_access_in,
   input  wire logic                    capture_second_access_in,
   input  wire logic                    compare_first_access_in,
   input  wire logic                    compare_second_access_in,
   input  wire logic                    counter_access_in,
   input  wire logic                    trigger_input_pin_in,
   input  wire logic                    second_capture_pin_in,
   output logic                         pulse_output_pin_out,
   output logic                         pulse_output_oe_out,
   output logic [7:0]                   counter_out,
   output logic [7:0]                   capture_value_first_out,
   output logic [7:0]                   capture_value_second_out,
   output logic [4:0]                   timer_status_reg_out,
   output logic                         timer_irq_out,
   output logic                         wake_from_wait_out
);
   import timer8_pkg::*;

   timer_mode_t mode;
   logic        tick;
   logic [2:0]  trig_sync_q;
   logic [2:0]  cap2_sync_q;
   logic        trig_lvl_q;
   logic        cap2_lvl_q;
   logic        trig_edge;
   logic        cap2_edge;
   logic        halt_q;
   logic        halt_exit;
   logic        trig_armed_q;
   logic        cap2_armed_q;
   logic [7:0]  cnt_q;
   logic [7:0]  cmp1_act_q;
   logic [7:0]  cmp2_act_q;
   logic        cmp1_hit;
   logic        cmp2_hit;
   logic        capture_flag_first_q;
   logic        capture_flag_second_q;
   logic        compare_flag_first_q;
   logic        compare_flag_second_q;
   logic        tof_q;
   logic [4:0]  seen_q;
   logic        trig_evt;
   logic        cap2_evt;
   logic        pwm_period_end;
   logic        ovf_evt;
   logic        irq_d;
   logic        presc_restart;

   // Edge of a synchronised pin level, direction from the select bit
   function automatic logic edge_hit(input logic prev, input logic now, input logic rising);
      edge_hit = rising ? (!prev && now) : (prev && !now);
   endfunction

   // Status-read-then-access clear; a set in the same cycle wins
   function automatic logic flag_next(input logic q, input logic set, input logic seen,
                                      input logic access);
      flag_next = set | (q & !(seen & access));
   endfunction

   always_comb begin
      if (pwm_select_in) begin
         mode = MODE_PWM;
      end else if (one_shot_select_in) begin
         mode = MODE_ONE_SHOT;
      end else begin
         mode = MODE_PLAIN;
      end
   end

   // A free-running divider would cut the first pulse tick short by a random phase
   assign presc_restart = reset_in || (mode == MODE_ONE_SHOT && trig_evt);

   timer8_prescaler #(.SLOW_DIV(SLOW_DIV)) u_presc (
      .clk_sys_in (clk_sys_in),
      .reset_in   (presc_restart),
      .run_in     (!halt_in),
      .div_sel_in (clock_division_field_in),
      .tick_out   (tick)
   );

   // Three-stage pin sync; a change counts once stages two and three agree
   always_ff @(posedge clk_sys_in) begin
      if (reset_in) begin
         trig_sync_q <= '0;
         cap2_sync_q <= '0;
      end else begin
         trig_sync_q <= {trig_sync_q[1:0], trigger_input_pin_in};
         cap2_sync_q <= {cap2_sync_q[1:0], second_capture_pin_in};
      end
   end

   always_ff @(posedge clk_sys_in) begin
      if (reset_in) begin
         trig_lvl_q <= 1'b0;
         cap2_lvl_q <= 1'b0;
      end else begin
         if (trig_sync_q[1] == trig_sync_q[2]) begin
            trig_lvl_q <= trig_sync_q[2];
         end
         if (cap2_sync_q[1] == cap2_sync_q[2]) begin
            cap2_lvl_q <= cap2_sync_q[2];
         end
      end
   end

   assign trig_edge = (trig_sync_q[1] == trig_sync_q[2]) &&
                      edge_hit(trig_lvl_q, trig_sync_q[2], trigger_edge_select_in);
   assign cap2_edge = (cap2_sync_q[1] == cap2_sync_q[2]) &&
                      edge_hit(cap2_lvl_q, cap2_sync_q[2], second_edge_select_in);

   // Edges seen while halted only arm; the event fires at halt exit
   always_ff @(posedge clk_sys_in) begin
      if (reset_in) begin
         halt_q       <= 1'b0;
         trig_armed_q <= 1'b0;
         cap2_armed_q <= 1'b0;
      end else begin
         halt_q <= halt_in;
         if (halt_exit) begin
            trig_armed_q <= 1'b0;
            cap2_armed_q <= 1'b0;
         end else if (halt_in) begin
            trig_armed_q <= trig_armed_q | (trig_edge && mode != MODE_PWM);
            cap2_armed_q <= cap2_armed_q | cap2_edge;
         end
      end
   end

   assign halt_exit = halt_q && !halt_in;
   assign trig_evt  = mode != MODE_PWM &&
                      ((trig_edge && !halt_in) || (halt_exit && trig_armed_q));
   assign cap2_evt  = (cap2_edge && !halt_in) || (halt_exit && cap2_armed_q);
   assign cmp1_hit  = tick && cnt_q == cmp1_act_q;
   assign cmp2_hit  = tick && cnt_q == cmp2_act_q;
   assign pwm_period_end = mode == MODE_PWM && cmp2_hit;
   assign ovf_evt   = tick && cnt_q == 8'hff && !pwm_period_end &&
                      !(mode == MODE_ONE_SHOT && trig_evt);

   // Counter; halt freezes the tick, so wait mode and wake-up need nothing special
   always_ff @(posedge clk_sys_in) begin
      if (reset_in) begin
         cnt_q <= CNT_RESET_VAL;
      end else if (mode == MODE_ONE_SHOT && trig_evt) begin
         cnt_q <= CNT_RELOAD_VAL;
      end else if (pwm_period_end) begin
         cnt_q <= CNT_RELOAD_VAL;
      end else if (tick) begin
         cnt_q <= cnt_q + 8'h01;
      end
   end

   // Compare shadows: live outside PWM, reloaded only at period end in PWM
   always_ff @(posedge clk_sys_in) begin
      if (reset_in) begin
         cmp1_act_q <= CMP_RESET_VAL;
         cmp2_act_q <= CMP_RESET_VAL;
      end else if (mode != MODE_PWM || pwm_period_end) begin
         cmp1_act_q <= compare_value_first_in;
         cmp2_act_q <= compare_value_second_in;
      end
   end

   // Capture registers; the one-shot trigger stores the fixed low byte
   always_ff @(posedge clk_sys_in) begin
      if (reset_in) begin
         capture_value_first_out  <= '0;
         capture_value_second_out <= '0;
      end else begin
         if (trig_evt) begin
            capture_value_first_out <= (mode == MODE_ONE_SHOT) ? CAPTURE_TRIG_VAL : cnt_q;
         end
         if (cap2_evt) begin
            capture_value_second_out <= cnt_q;
         end
      end
   end

   // Output pin; stays idle low until the mode drives it
   always_ff @(posedge clk_sys_in) begin
      if (reset_in) begin
         pulse_output_pin_out <= 1'b0;
      end else if (mode == MODE_PWM) begin
         if (pwm_period_end) begin
            pulse_output_pin_out <= during_pulse_level_in;
         end else if (cmp1_hit) begin
            pulse_output_pin_out <= after_pulse_level_in;
         end else if (after_pulse_level_in == during_pulse_level_in) begin
            pulse_output_pin_out <= after_pulse_level_in;
         end
      end else if (mode == MODE_ONE_SHOT) begin
         if (trig_evt) begin
            pulse_output_pin_out <= during_pulse_level_in;
         end else if (cmp1_hit) begin
            pulse_output_pin_out <= after_pulse_level_in;
         end else if (after_pulse_level_in == during_pulse_level_in) begin
            pulse_output_pin_out <= after_pulse_level_in;
         end
      end else if (cmp1_hit) begin
         pulse_output_pin_out <= after_pulse_level_in;
      end
   end

   always_ff @(posedge clk_sys_in) begin
      if (reset_in) begin
         pulse_output_oe_out <= 1'b0;
      end else begin
         pulse_output_oe_out <= pulse_pin_enable_in;
      end
   end

   // Status-read memory: which flags a status read saw set
   always_ff @(posedge clk_sys_in) begin
      if (reset_in) begin
         seen_q <= '0;
      end else if (status_read_in) begin
         seen_q <= {capture_flag_first_q, capture_flag_second_q, compare_flag_first_q, compare_flag_second_q, tof_q};
      end
   end

   always_ff @(posedge clk_sys_in) begin
      if (reset_in) begin
         capture_flag_first_q <= 1'b0;
         capture_flag_second_q <= 1'b0;
         compare_flag_first_q <= 1'b0;
         compare_flag_second_q <= 1'b0;
         tof_q  <= 1'b0;
      end else begin
         capture_flag_first_q <= flag_next(capture_flag_first_q, trig_evt || pwm_period_end, seen_q[4],
                             capture_first_access_in);
         capture_flag_second_q <= flag_next(capture_flag_second_q, cap2_evt, seen_q[3], capture_second_access_in);
         compare_flag_first_q <= flag_next(compare_flag_first_q, cmp1_hit && mode == MODE_PLAIN, seen_q[2],
                             compare_first_access_in);
         compare_flag_second_q <= flag_next(compare_flag_second_q, cmp2_hit && mode != MODE_PWM, seen_q[1],
                             compare_second_access_in);
         tof_q  <= flag_next(tof_q, ovf_evt, seen_q[0], counter_access_in);
      end
   end

   // Halt blocks the request so timer events never end halt
   assign irq_d = !global_mask_in && !halt_in &&
                  ((capture_irq_enable_in && (capture_flag_first_q || capture_flag_second_q)) ||
                   (compare_irq_enable_in && (compare_flag_first_q || compare_flag_second_q)) ||
                   (overflow_irq_enable_in && tof_q));

   always_ff @(posedge clk_sys_in) begin
      if (reset_in) begin
         timer_irq_out      <= 1'b0;
         wake_from_wait_out <= 1'b0;
         counter_out        <= CNT_RESET_VAL;
         timer_status_reg_out <= '0;
      end else begin
         timer_irq_out      <= irq_d;
         wake_from_wait_out <= irq_d;
         counter_out        <= cnt_q;
         timer_status_reg_out <= {capture_flag_first_q, capture_flag_second_q, compare_flag_first_q, compare_flag_second_q, tof_q};
      end
   end

   a_oneshot_reload: assert property (@(posedge clk_sys_in) disable iff (reset_in)
      (mode == MODE_ONE_SHOT && trig_evt) |=> cnt_q == CNT_RELOAD_VAL && capture_flag_first_q)
      else $error("one-shot trigger did not reload counter and set flag");
   a_oneshot_level: assert property (@(posedge clk_sys_in) disable iff (reset_in)
      (mode == MODE_ONE_SHOT && trig_evt) |=> pulse_output_pin_out == $past(during_pulse_level_in))
      else $error("one-shot trigger did not drive during-pulse level");
   a_oneshot_end: assert property (@(posedge clk_sys_in) disable iff (reset_in)
      (mode == MODE_ONE_SHOT && !trig_evt && cmp1_hit) |=>
      pulse_output_pin_out == $past(after_pulse_level_in))
      else $error("one-shot compare did not drive after-pulse level");
   a_no_compare_flag_first_oneshot: assert property (@(posedge clk_sys_in) disable iff (reset_in)
      (mode != MODE_PLAIN && !compare_flag_first_q) |=> !compare_flag_first_q || $past(mode) == MODE_PLAIN)
      else $error("compare flag one set in one-shot or PWM");
   a_pwm_reload: assert property (@(posedge clk_sys_in) disable iff (reset_in)
      pwm_period_end |=> cnt_q == CNT_RELOAD_VAL && capture_flag_first_q &&
      cmp2_act_q == $past(compare_value_second_in))
      else $error("PWM period end did not reload counter");
   a_pwm_shadow_hold: assert property (@(posedge clk_sys_in) disable iff (reset_in)
      (mode == MODE_PWM && !pwm_period_end && $past(mode) == MODE_PWM) |=>
      $stable(cmp1_act_q))
      else $error("PWM compare shadow changed mid-period");
   a_pwm_no_compare_flag_second: assert property (@(posedge clk_sys_in) disable iff (reset_in)
      (mode == MODE_PWM && cmp2_hit && !compare_flag_second_q) |=> !compare_flag_second_q)
      else $error("compare flag two set in PWM");
   a_irq_gated: assert property (@(posedge clk_sys_in) disable iff (reset_in)
      (global_mask_in || halt_in) |=> !timer_irq_out)
      else $error("interrupt raised while masked or halted");
   a_halt_freeze: assert property (@(posedge clk_sys_in) disable iff (reset_in)
      (halt_in && $past(halt_in) && !trig_evt) |=> $stable(cnt_q))
      else $error("counter moved during halt");
endmodule

// ### bench/pin_far_side.sv
// Far-side pin model: drives both capture pins and times the pulse output pin
`timescale 1ns/1ns
module pin_far_side (
   input  wire logic        clk_sys_in,
   input  wire logic        pulse_pin_in,
   input  wire logic        watch_level_in,
   output logic             trigger_pin_out,
   output logic             second_pin_out,
   output logic [15:0]      run_len_out
);
   logic [15:0] run_q = 16'h0000;
   initial begin
      trigger_pin_out = 1'b0;
      second_pin_out  = 1'b0;
      run_len_out     = 16'h0000;
   end
   // Keeps the length of the latest finished stretch at the watched level
   always @(posedge clk_sys_in) begin
      if (pulse_pin_in === watch_level_in) begin
         run_q <= run_q + 16'h0001;
      end else begin
         if (run_q != 16'h0000) begin
            run_len_out <= run_q;
         end
         run_q <= 16'h0000;
      end
   end
   // Levels are held until the next call, so the synchroniser always sees them
   task automatic drive_edge(input logic on_trigger, input logic level);
      @(posedge clk_sys_in);
      #1;
      if (on_trigger) begin
         trigger_pin_out = level;
      end else begin
         second_pin_out = level;
      end
   endtask
endmodule

// ### bench/timer8_pulse_core_tb.sv
// Self-checking bench for the one-shot/PWM timer core
`timescale 1ns/1ns
module timer8_pulse_core_tb;
   import timer8_pkg::*;
   localparam int SLOW = 16;
   logic        clk_sys_in = 1'b0;
   logic        reset_in = 1'b1;
   logic        halt = 1'b0, mask = 1'b0, osel = 1'b0, psel = 1'b0, pin_en = 1'b0;
   logic        after = 1'b0, during = 1'b0, edge1 = 1'b1, edge2 = 1'b1, watch = 1'b1;
   logic        cie = 1'b0, oie = 1'b0, tie = 1'b0;
   logic        rd = 1'b0, ac1 = 1'b0, ac2 = 1'b0, ao1 = 1'b0, ao2 = 1'b0, actr = 1'b0;
   logic [1:0]  div = DIV_SEL_2;
   logic [7:0]  cmp1 = 8'h00, cmp2 = 8'h00, cnt, cap1, cap2, c0;
   logic        trig, sec, pin, oe, irq, wake;
   logic [4:0]  st;
   logic [15:0] run_len;
   int          err_total = 0, n_compared = 0, cycles = 0;

   timer8_pulse_core #(.SLOW_DIV(SLOW)) dut_u (
      .clk_sys_in(clk_sys_in), .reset_in(reset_in), .halt_in(halt),
      .global_mask_in(mask), .one_shot_select_in(osel), .pwm_select_in(psel),
      .pulse_pin_enable_in(pin_en), .clock_division_field_in(div),
      .after_pulse_level_in(after), .during_pulse_level_in(during),
      .trigger_edge_select_in(edge1), .second_edge_select_in(edge2),
      .capture_irq_enable_in(cie), .compare_irq_enable_in(oie),
      .overflow_irq_enable_in(tie), .compare_value_first_in(cmp1),
      .compare_value_second_in(cmp2), .status_read_in(rd),
      .capture_first_access_in(ac1), .capture_second_access_in(ac2),
      .compare_first_access_in(ao1), .compare_second_access_in(ao2),
      .counter_access_in(actr), .trigger_input_pin_in(trig),
      .second_capture_pin_in(sec), .pulse_output_pin_out(pin),
      .pulse_output_oe_out(oe), .counter_out(cnt), .capture_value_first_out(cap1),
      .capture_value_second_out(cap2), .timer_status_reg_out(st),
      .timer_irq_out(irq), .wake_from_wait_out(wake));
   pin_far_side far_u (
      .clk_sys_in(clk_sys_in), .pulse_pin_in(pin), .watch_level_in(watch),
      .trigger_pin_out(trig), .second_pin_out(sec), .run_len_out(run_len));

   always #5 clk_sys_in = ~clk_sys_in;
   // A hang ends the run through the same closing report
   always @(posedge clk_sys_in) begin
      cycles++;
      if (cycles == 20000) begin
         err_total++;
         tally_and_finish();
      end
   end

   task automatic tally_and_finish;
      $display("Counts: compared=%0d mismatches=%0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   task automatic step(input int n);
      repeat (n) @(posedge clk_sys_in);
      #1;
   endtask
   task automatic check(input logic [15:0] seen, input logic [15:0] want);
      n_compared++;
      if (seen !== want) begin
         err_total++;
         $display("ERROR t=%0t seen=%h want=%h", $time, seen, want);
      end
   endtask
   task automatic pulse(ref logic s);
      s = 1'b1;
      step(1);
      s = 1'b0;
   endtask
   task automatic wait_flag(input int idx, input int lim);
      for (int i = 0; i < lim && st[idx] !== 1'b1; i++) begin
         step(1);
      end
   endtask
   // Flag clear needs the status read first, then the register access
   task automatic clear_seen(ref logic acc);
      pulse(rd);
      pulse(acc);
      step(2);
   endtask

   task automatic t_one_shot;
      cmp1 = 8'h03;
      cmp2 = 8'h10;
      during = 1'b1;
      pin_en = 1'b1;
      osel = 1'b1;
      cie = 1'b1;
      step(4);
      check(oe, 1'b1);
      far_u.drive_edge(1'b1, 1'b1);
      wait_flag(4, 16);
      check(st[4], 1'b1);
      check(cap1, CAPTURE_TRIG_VAL);
      check(pin, 1'b1);
      check(irq, 1'b1);
      check(wake, 1'b1);
      mask = 1'b1;
      step(2);
      check(irq, 1'b0);
      mask = 1'b0;
      for (int i = 0; i < 100 && pin !== 1'b0; i++) begin
         step(1);
      end
      step(2);
      check(run_len, 16'((cmp1 + 5) * PRESC_2));
      check(st[2], 1'b0);
      c0 = cnt;
      step(4);
      check(cnt, c0 + 8'h02);
      check(pin, 1'b0);
      wait_flag(1, 600);
      check(st[1], 1'b1);
      $display("test one_shot done");
   endtask

   task automatic t_halt_and_second;
      halt = 1'b1;
      step(2);
      c0 = cnt;
      far_u.drive_edge(1'b0, 1'b1);
      step(8);
      check(cnt, c0);
      check({irq, st[3]}, 2'h0);
      halt = 1'b0;
      step(4);
      check(st[3], 1'b1);
      check(cap2, c0);
      check(cnt !== c0, 1'b1);
      clear_seen(ac2);
      edge2 = 1'b0;
      far_u.drive_edge(1'b0, 1'b0);
      wait_flag(3, 16);
      check(st[3], 1'b1);
      $display("test halt_and_second done");
   endtask

   task automatic t_clear_and_polarity;
      clear_seen(ac1);
      check(st[4], 1'b0);
      // Status read while flag one is clear, so the next access alone must not clear it
      pulse(rd);
      edge1 = 1'b0;
      far_u.drive_edge(1'b1, 1'b0);
      wait_flag(4, 16);
      check(st[4], 1'b1);
      pulse(ac1);
      step(2);
      check(st[4], 1'b1);
      clear_seen(ac1);
      far_u.drive_edge(1'b1, 1'b1);
      step(12);
      check(st[4], 1'b0);
      $display("test clear_and_polarity done");
   endtask

   task automatic t_division;
      logic [1:0] codes [4] = '{DIV_SEL_2, DIV_SEL_4, DIV_SEL_8, DIV_SEL_8000};
      int         facts [4] = '{PRESC_2, PRESC_4, PRESC_8, SLOW};
      check(st[0], 1'b1);
      for (int i = 0; i < 4; i++) begin
         div = codes[i];
         step(2 * facts[i]);
         c0 = cnt;
         step(8 * facts[i]);
         check(cnt, c0 + 8'h08);
      end
      div = DIV_SEL_2;
      $display("test division done");
   endtask

   task automatic t_pwm;
      psel = 1'b1;
      cmp1 = 8'h02;
      cmp2 = 8'h06;
      clear_seen(ac1);
      clear_seen(ao2);
      wait_flag(4, 600);
      check(st[4], 1'b1);
      step(50);
      far_u.drive_edge(1'b1, 1'b0);
      step(10);
      check(run_len, 16'((cmp1 + 5) * PRESC_2));
      check(st[2:1], 2'h0);
      after = 1'b1;
      during = 1'b0;
      cmp1 = 8'h03;
      step(60);
      check(run_len, 16'((cmp2 - cmp1) * PRESC_2));
      during = 1'b1;
      step(4);
      for (int i = 0; i < 30; i++) begin
         check(pin, 1'b1);
         step(1);
      end
      $display("test pwm done");
   endtask

   initial begin
      step(4);
      check(cnt, CNT_RESET_VAL);
      check({st, pin, oe, irq}, 8'h00);
      reset_in = 1'b0;
      step(1);
      t_one_shot();
      t_halt_and_second();
      t_clear_and_polarity();
      t_division();
      t_pwm();
      tally_and_finish();
   end
endmodule
